// ===== src/field_threshold_trim_filter_cfg.sv
// field threshold, bias trim and filter window configuration with its serial register port
// assumes spi pins and field samples are synchronous to mclk; sclk is much slower than mclk
//
// Notes on behaviour
// - bias trim amount is 8-bit, 0 to 255
// - each axis trims only when its enable set
// - both enables give equal reduction on both
// - trim amount resets to zero
// - flags assert when field leaves threshold range
// - 6 mT hysteresis between rising and falling
// - thresholds in register 6, bits 7:5, 4:2
// - codes map to 26..126 mT rising points
// - low code may exceed high code
// - status register 27: high bit 7, low 6
// - each flag drives its own output pin
// - status returned in the following transfer
// - angle output ignores both field flags
// - filter window value sets time constant, cutoff
// - start-up time follows filter window setting
// - range code 0011 in, 1111 above, 0000 below
`timescale 1ns/1ps
`include "field_cfg_map.svh"

module field_threshold_trim_filter_cfg #(
   parameter int cycles_per_us = `MCLK_MHZ   // mclk cycles per microsecond for start-up timing
) (
   input  wire logic                            mclk,
   input  wire logic                            rst,
   input  wire logic                            spi_sclk,
   input  wire logic                            spi_cs_n,
   input  wire logic                            spi_mosi,
   output logic                                 spi_miso,
   output logic                                 spi_miso_oe,
   input  wire logic                            sample_valid,
   input  wire logic [7:0]                      field_mt,
   input  wire logic                            hall_ok,
   input  wire logic [15:0]                     angle_in,
   output logic [15:0]                          angle_out,
   output logic                                 field_low_flag_pin,
   output logic                                 field_high_flag_pin,
   output field_cfg_pkg::trim_out_type          trim_out,
   output field_cfg_pkg::filter_out_type        filter_out,
   output logic                                 startup_done
);
   import field_cfg_pkg::*;

   // window step from the filter value; off-grid values fall to the step below
   function automatic logic [3:0] window_index(input logic [7:0] fw);
      logic [3:0] idx;
      idx = 4'h0;
      for (int k = 1; k <= 8; k++) begin
         if (fw >= `FW_BASE + 8'(k) * `FW_STEP) begin
            idx = 4'(k);
         end
      end
      window_index = idx;
   endfunction

   // start-up time in microseconds per window step
   function automatic logic [19:0] startup_us(input logic [3:0] idx);
      unique case (idx)
         4'h0:    startup_us = `STARTUP_US_0;
         4'h1:    startup_us = `STARTUP_US_1;
         4'h2:    startup_us = `STARTUP_US_2;
         4'h3:    startup_us = `STARTUP_US_3;
         4'h4:    startup_us = `STARTUP_US_4;
         4'h5:    startup_us = `STARTUP_US_5;
         4'h6:    startup_us = `STARTUP_US_6;
         4'h7:    startup_us = `STARTUP_US_7;
         default: startup_us = `STARTUP_US_8;   // index never exceeds 8
      endcase
   endfunction

   // cutoff frequency per window step
   function automatic logic [12:0] cutoff_hz(input logic [3:0] idx);
      unique case (idx)
         4'h0:    cutoff_hz = `CUTOFF_HZ_0;
         4'h1:    cutoff_hz = `CUTOFF_HZ_1;
         4'h2:    cutoff_hz = `CUTOFF_HZ_2;
         4'h3:    cutoff_hz = `CUTOFF_HZ_3;
         4'h4:    cutoff_hz = `CUTOFF_HZ_4;
         4'h5:    cutoff_hz = `CUTOFF_HZ_5;
         4'h6:    cutoff_hz = `CUTOFF_HZ_6;
         4'h7:    cutoff_hz = `CUTOFF_HZ_7;
         default: cutoff_hz = `CUTOFF_HZ_8;   // index never exceeds 8
      endcase
   endfunction

   // ---------------- serial port ----------------
   spi_state_type spi_state_ff;       // frame receiver state
   spi_state_type nxt_spi_state;      // next receiver state
   logic          sclk_prev_ff;       // sclk one cycle ago, for edge detection
   logic          cs_prev_ff;         // chip select one cycle ago
   logic [15:0]   rx_ff;              // incoming frame shift register
   logic [4:0]    bit_cnt_ff;         // bits taken in this frame
   logic [15:0]   tx_ff;              // outgoing shift register, msb on the pin
   logic [7:0]    reply_ff;           // byte waiting for the next transfer
   logic          miso_oe_ff;         // drive enable for the data out pin
   logic          sclk_rise;          // sampling edge inside a frame
   logic          sclk_fall;          // launching edge inside a frame
   logic          cs_fall;            // start of a frame
   logic [15:0]   frame;              // complete frame including the last bit
   logic          frame_done;         // sixteenth bit taken this cycle
   logic [2:0]    frame_cmd;          // command field
   logic [4:0]    frame_addr;         // address field
   logic [7:0]    frame_data;         // data field
   logic          wr_hit;             // write command completed

   // ---------------- configuration ----------------
   logic [7:0]    trim_amount_ff;     // bias trim amount
   logic [1:0]    trim_en_ff;         // per-axis trim enables
   logic [2:0]    low_thr_ff;         // low field threshold code
   logic [2:0]    high_thr_ff;        // high field threshold code
   logic [7:0]    fw_ff;              // filter window value
   logic [7:0]    act_amount_ff;      // trim amount in use by the front end
   logic [1:0]    act_en_ff;          // trim enables in use
   logic [2:0]    act_low_ff;         // low code in use by the comparator
   logic [2:0]    act_high_ff;        // high code in use by the comparator
   logic [7:0]    act_fw_ff;          // window in use by the filter
   logic [3:0]    act_idx;            // window step of the window in use

   // ---------------- status and timing ----------------
   logic          low_flag;           // low field alarm
   logic          high_flag;          // high field alarm
   logic [3:0]    range_code_ff;      // field range code
   logic [31:0]   startup_cnt_ff;     // cycles since reset release
   logic [31:0]   startup_limit;      // cycles the current window needs
   logic          startup_done_ff;    // front end has settled
   logic          flag_sample;        // sample accepted by the comparators
   logic [15:0]   angle_ff;           // registered angle
   trim_out_type  trim_ff;            // registered trim outputs
   filter_out_type filter_ff;         // registered filter outputs

   assign sclk_rise  = spi_sclk & ~sclk_prev_ff & ~spi_cs_n;
   assign sclk_fall  = ~spi_sclk & sclk_prev_ff & ~spi_cs_n;
   assign cs_fall    = ~spi_cs_n & cs_prev_ff;
   assign frame      = {rx_ff[14:0], spi_mosi};
   assign frame_done = (spi_state_ff == spi_shift) && sclk_rise && (bit_cnt_ff == `SPI_FRAME_BITS - 5'h1);
   assign frame_cmd  = frame[15:13];
   assign frame_addr = frame[12:8];
   assign frame_data = frame[7:0];
   assign wr_hit     = frame_done && (frame_cmd == `SPI_CMD_WRITE);

   // pin history for edge detection
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sclk_prev_ff <= 1'b0;
         cs_prev_ff   <= 1'b1;
      end else begin
         sclk_prev_ff <= spi_sclk;
         cs_prev_ff   <= spi_cs_n;
      end
   end

   // receiver state: bits past the sixteenth are ignored until chip select rises
   always_comb begin
      nxt_spi_state = spi_state_ff;
      unique case (spi_state_ff)
         spi_idle: begin
            if (!spi_cs_n) begin
               nxt_spi_state = spi_shift;
            end
         end
         spi_shift: begin
            if (spi_cs_n) begin
               nxt_spi_state = spi_idle;   // short frame is dropped
            end else if (frame_done) begin
               nxt_spi_state = spi_done;
            end
         end
         spi_done: begin
            if (spi_cs_n) begin
               nxt_spi_state = spi_idle;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         spi_state_ff <= spi_idle;
      end else begin
         spi_state_ff <= nxt_spi_state;
      end
   end

   // shift in on the rising edge, msb first
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_ff      <= 16'h0000;
         bit_cnt_ff <= 5'h00;
      end else if (spi_state_ff != spi_shift) begin
         bit_cnt_ff <= 5'h00;
      end else if (sclk_rise) begin
         rx_ff      <= frame;
         bit_cnt_ff <= bit_cnt_ff + 5'h1;
      end
   end

   // reply for the next transfer; status is snapshot when the read frame ends
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reply_ff <= 8'h00;
      end else if (frame_done) begin
         if (frame_cmd == `SPI_CMD_READ) begin
            unique case (frame_addr)
               `ADDR_BIAS_TRIM:       reply_ff <= trim_amount_ff;
               `ADDR_TRIM_ENABLE:     reply_ff <= {6'h00, trim_en_ff};
               `ADDR_FIELD_THRESHOLD: reply_ff <= {low_thr_ff, high_thr_ff, 2'h0};
               `ADDR_FILTER_WINDOW:   reply_ff <= fw_ff;
               `ADDR_FIELD_STATUS:    reply_ff <= {high_flag, low_flag, range_code_ff, 2'h0};
               default:               reply_ff <= 8'h00;   // unmapped reads return zero
            endcase
         end else begin
            reply_ff <= 8'h00;   // only a read leaves data behind
         end
      end
   end

   // shift out: first bit ready at frame start, later bits launched on falling sclk
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_ff      <= 16'h0000;
         miso_oe_ff <= 1'b0;
      end else begin
         miso_oe_ff <= ~spi_cs_n;
         if (cs_fall) begin
            tx_ff <= {reply_ff, 8'h00};
         end else if (sclk_fall) begin
            tx_ff <= {tx_ff[14:0], 1'b0};
         end
      end
   end

   // ---------------- configuration registers ----------------

   // trim amount and enables; full 0..255 range, no bias reduction after reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         trim_amount_ff <= `RST_BIAS_TRIM;
         trim_en_ff     <= `RST_TRIM_ENABLE;
      end else if (wr_hit) begin
         if (frame_addr == `ADDR_BIAS_TRIM) begin
            trim_amount_ff <= frame_data;
         end
         if (frame_addr == `ADDR_TRIM_ENABLE) begin
            trim_en_ff <= {frame_data[`TRIM_Y_BIT], frame_data[`TRIM_X_BIT]};
         end
      end
   end

   // threshold codes; any order of low and high is accepted as written
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         low_thr_ff  <= `RST_LOW_THR;
         high_thr_ff <= `RST_HIGH_THR;
      end else if (wr_hit && frame_addr == `ADDR_FIELD_THRESHOLD) begin
         low_thr_ff  <= frame_data[`LOW_THR_MSB:`LOW_THR_LSB];
         high_thr_ff <= frame_data[`HIGH_THR_MSB:`HIGH_THR_LSB];
      end
   end

   // filter window value
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fw_ff <= `RST_FILTER_WINDOW;
      end else if (wr_hit && frame_addr == `ADDR_FILTER_WINDOW) begin
         fw_ff <= frame_data;
      end
   end

   // settings move into use on a sample boundary, so one sample never sees a mix
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         act_amount_ff <= `RST_BIAS_TRIM;
         act_en_ff     <= `RST_TRIM_ENABLE;
         act_low_ff    <= `RST_LOW_THR;
         act_high_ff   <= `RST_HIGH_THR;
         act_fw_ff     <= `RST_FILTER_WINDOW;
      end else if (sample_valid) begin
         act_amount_ff <= trim_amount_ff;
         act_en_ff     <= trim_en_ff;
         act_low_ff    <= low_thr_ff;
         act_high_ff   <= high_thr_ff;
         act_fw_ff     <= fw_ff;
      end
   end

   // per-axis reduction; both enabled gives the same cut on both axes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         trim_ff <= '0;
      end else begin
         trim_ff.x_amount <= act_en_ff[`TRIM_X_BIT] ? act_amount_ff : 8'h00;
         trim_ff.y_amount <= act_en_ff[`TRIM_Y_BIT] ? act_amount_ff : 8'h00;
      end
   end

   // filter time constant doubles per window step while cutoff halves
   assign act_idx = window_index(act_fw_ff);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         filter_ff <= '0;
      end else begin
         filter_ff.window_index <= act_idx;
         filter_ff.tau_us       <= `TAU_BASE_US << act_idx;
         filter_ff.cutoff_hz    <= cutoff_hz(act_idx);
      end
   end

   // ---------------- start-up and field flags ----------------

   // start-up length tracks the window; a write during start-up re-times it
   assign startup_limit = 32'(startup_us(window_index(fw_ff))) * 32'(cycles_per_us);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         startup_cnt_ff  <= 32'h0000_0000;
         startup_done_ff <= 1'b0;
      end else if (!startup_done_ff) begin
         startup_cnt_ff <= startup_cnt_ff + 32'h0000_0001;
         if (startup_cnt_ff + 32'h0000_0001 >= startup_limit) begin
            startup_done_ff <= 1'b1;
         end
      end
   end

   // samples before the front end settles are not trusted by the comparators
   assign flag_sample = sample_valid & startup_done_ff;

   field_flag_detector #(
      .high_side (1'b0)
   ) u_low_flag (
      .mclk         (mclk),
      .rst          (rst),
      .sample_valid (flag_sample),
      .field_mt     (field_mt),
      .thr_code     (act_low_ff),
      .flag         (low_flag)
   );

   field_flag_detector #(
      .high_side (1'b1)
   ) u_high_flag (
      .mclk         (mclk),
      .rst          (rst),
      .sample_valid (flag_sample),
      .field_mt     (field_mt),
      .thr_code     (act_high_ff),
      .flag         (high_flag)
   );

   // range code; a crossed pair of thresholds can raise both flags, shown as a separate code
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         range_code_ff <= `RANGE_BELOW;
      end else begin
         if (high_flag && low_flag) begin
            range_code_ff <= `RANGE_CONFLICT;
         end else if (high_flag) begin
            range_code_ff <= `RANGE_ABOVE;
         end else if (low_flag) begin
            range_code_ff <= `RANGE_BELOW;
         end else if (hall_ok && startup_done_ff) begin
            range_code_ff <= `RANGE_IN;
         end else begin
            range_code_ff <= `RANGE_HALL_FAULT;   // front end not acquiring
         end
      end
   end

   // angle passes through untouched by any alarm state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         angle_ff <= 16'h0000;
      end else if (sample_valid) begin
         angle_ff <= angle_in;
      end
   end

   // ---------------- outputs ----------------
   assign spi_miso            = tx_ff[15];
   assign spi_miso_oe         = miso_oe_ff;
   assign field_low_flag_pin  = low_flag;
   assign field_high_flag_pin = high_flag;
   assign angle_out           = angle_ff;
   assign trim_out            = trim_ff;
   assign filter_out          = filter_ff;
   assign startup_done        = startup_done_ff;

endmodule

// ===== pkg/field_cfg_map.svh
// register offsets, field positions, reset values and timing figures of the field configuration block
// assumes nothing; included by the package users and the flag detector
`ifndef FIELD_CFG_MAP_SVH
`define FIELD_CFG_MAP_SVH

// register addresses on the 5-bit serial address field
`define ADDR_BIAS_TRIM       5'h02
`define ADDR_TRIM_ENABLE     5'h03
`define ADDR_FIELD_THRESHOLD 5'h06
`define ADDR_FILTER_WINDOW   5'h0E
`define ADDR_FIELD_STATUS    5'h1B

// serial command codes in the top three bits of a frame
`define SPI_CMD_READ         3'h2
`define SPI_CMD_WRITE        3'h4
`define SPI_FRAME_BITS       5'h10

// field positions
`define TRIM_X_BIT           0
`define TRIM_Y_BIT           1
`define LOW_THR_MSB          7
`define LOW_THR_LSB          5
`define HIGH_THR_MSB         4
`define HIGH_THR_LSB         2
`define STATUS_HIGH_BIT      7
`define STATUS_LOW_BIT       6

// reset values
`define RST_BIAS_TRIM        8'h00
`define RST_TRIM_ENABLE      2'h0
`define RST_LOW_THR          3'h0
`define RST_HIGH_THR         3'h7
`define RST_FILTER_WINDOW    8'h77

// range codes
`define RANGE_IN             4'h3
`define RANGE_ABOVE          4'hF
`define RANGE_BELOW          4'h0
`define RANGE_HALL_FAULT     4'h1
`define RANGE_CONFLICT       4'h9

// rising trip points in mT for codes 0 to 7, and the hysteresis
`define TRIP_MT_0            8'h1A
`define TRIP_MT_1            8'h29
`define TRIP_MT_2            8'h38
`define TRIP_MT_3            8'h46
`define TRIP_MT_4            8'h54
`define TRIP_MT_5            8'h62
`define TRIP_MT_6            8'h70
`define TRIP_MT_7            8'h7E
`define HYSTERESIS_MT        8'h06

// filter window steps, time constant base and cutoff in Hz
`define FW_BASE              8'h33
`define FW_STEP              8'h11
`define FW_STEPS             4'h8
`define TAU_BASE_US          15'h0040
`define CUTOFF_HZ_0          13'h1770
`define CUTOFF_HZ_1          13'h0BB8
`define CUTOFF_HZ_2          13'h05DC
`define CUTOFF_HZ_3          13'h02E4
`define CUTOFF_HZ_4          13'h0172
`define CUTOFF_HZ_5          13'h00B9
`define CUTOFF_HZ_6          13'h005D
`define CUTOFF_HZ_7          13'h002E
`define CUTOFF_HZ_8          13'h0017

// start-up time in microseconds per window step, and the clock rate
`define STARTUP_US_0         20'h0_01F4
`define STARTUP_US_1         20'h0_044C
`define STARTUP_US_2         20'h0_09C4
`define STARTUP_US_3         20'h0_157C
`define STARTUP_US_4         20'h0_2EE0
`define STARTUP_US_5         20'h0_6590
`define STARTUP_US_6         20'h0_DEA8
`define STARTUP_US_7         20'h1_E078
`define STARTUP_US_8         20'h4_0740
`define MCLK_MHZ             100

`endif

// ===== pkg/field_cfg_pkg.sv
// types shared by the field configuration block, its port checks and its bench
// assumes the map header supplies all numeric constants
package field_cfg_pkg;

   // per-axis bias reduction that the front end applies
   typedef struct packed {
      logic [7:0] x_amount;   // reduction on the x hall device
      logic [7:0] y_amount;   // reduction on the y hall device
   } trim_out_type;

   // filter setting as seen by the angle filter
   typedef struct packed {
      logic [3:0]  window_index;   // 0 narrowest .. 8 widest
      logic [14:0] tau_us;         // time constant in microseconds
      logic [12:0] cutoff_hz;      // cutoff frequency in hertz
   } filter_out_type;

   // serial frame receiver state
   typedef enum logic [1:0] {
      spi_idle,
      spi_shift,
      spi_done
   } spi_state_type;

endpackage

// ===== src/field_flag_detector.sv
// one field alarm flag with hysteresis, high side or low side
// assumes field samples arrive with a one-cycle valid pulse on mclk
`timescale 1ns/1ps
`include "field_cfg_map.svh"

module field_flag_detector #(
   parameter bit high_side = 1'b1   // 1: alarm above threshold, 0: alarm below
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       sample_valid,
   input  wire logic [7:0] field_mt,
   input  wire logic [2:0] thr_code,
   output logic            flag
);

   // rising trip point for a 3-bit code
   function automatic logic [7:0] rise_point(input logic [2:0] code);
      unique case (code)
         3'h0: rise_point = `TRIP_MT_0;
         3'h1: rise_point = `TRIP_MT_1;
         3'h2: rise_point = `TRIP_MT_2;
         3'h3: rise_point = `TRIP_MT_3;
         3'h4: rise_point = `TRIP_MT_4;
         3'h5: rise_point = `TRIP_MT_5;
         3'h6: rise_point = `TRIP_MT_6;
         3'h7: rise_point = `TRIP_MT_7;
      endcase
   endfunction

   logic [7:0] rise_mt;   // switch point on a rising field
   logic [7:0] fall_mt;   // switch point on a falling field

   assign rise_mt = rise_point(thr_code);
   assign fall_mt = rise_mt - `HYSTERESIS_MT;

   // flag only moves on a new sample; the gap between points keeps it from chattering
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flag <= 1'b0;
      end else if (sample_valid) begin
         if (high_side) begin
            // set on rising past the upper point, clear below the lower
            if (!flag && field_mt >= rise_mt) begin
               flag <= 1'b1;
            end else if (flag && field_mt < fall_mt) begin
               flag <= 1'b0;
            end
         end else begin
            // set on falling below the lower point, clear once back at the upper
            if (!flag && field_mt < fall_mt) begin
               flag <= 1'b1;
            end else if (flag && field_mt >= rise_mt) begin
               flag <= 1'b0;
            end
         end
      end
   end

endmodule

// ===== tb/field_cfg_assertions.sv
// port checks of the field block
// assumes one domain, mclk with rst
`timescale 1ns/1ps
module field_cfg_assertions (
   input wire logic                          mclk,
   input wire logic                          rst,
   input wire logic                          sample_valid,
   input wire logic [7:0]                    field_mt,
   input wire logic [15:0]                   angle_in,
   input wire logic [15:0]                   angle_out,
   input wire logic                          field_low_flag_pin,
   input wire logic                          field_high_flag_pin,
   input wire field_cfg_pkg::trim_out_type   trim_out,
   input wire field_cfg_pkg::filter_out_type filter_out,
   input wire logic                          startup_done
);
   import field_cfg_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // samples move flags only once start-up is over
   wire go = startup_done && sample_valid;
   property p_ang; sample_valid |=> angle_out == $past(angle_in); endproperty
   a_ang: assert property (p_ang) else $error("angle");
   property p_hs; go && field_mt >= 8'h7E |=> field_high_flag_pin; endproperty
   a_hs: assert property (p_hs) else $error("high set");
   property p_ls; go && field_mt < 8'h14 |=> field_low_flag_pin; endproperty
   a_ls: assert property (p_ls) else $error("low set");
   property p_hc; go && field_mt < 8'h14 |=> !field_high_flag_pin; endproperty
   a_hc: assert property (p_hc) else $error("high clear");
   property p_lc; go && field_mt >= 8'h7E |=> !field_low_flag_pin; endproperty
   a_lc: assert property (p_lc) else $error("low clear");
   property p_st; !$past(sample_valid) |-> $stable({field_low_flag_pin, field_high_flag_pin}); endproperty
   a_st: assert property (p_st) else $error("flag moved");
   property p_tr; trim_out.x_amount && trim_out.y_amount |-> trim_out.x_amount == trim_out.y_amount; endproperty
   a_tr: assert property (p_tr) else $error("trim");
   property p_tau; filter_out.tau_us != 0 |-> filter_out.tau_us == 15'h0040 << filter_out.window_index; endproperty
   a_tau: assert property (p_tau) else $error("tau");
endmodule

// ===== tb/field_spi_host.sv
// spi host model: 16-bit mode 0 frames, msb first
// assumes xfer is called just after a rising mclk edge
`timescale 1ns/1ps
module field_spi_host (
   input wire logic mclk,
   input wire logic spi_miso,
   output logic     spi_sclk,
   output logic     spi_cs_n,
   output logic     spi_mosi
);
   // idle: deselected, clock still, data at pull-down level
   initial {spi_sclk, spi_cs_n, spi_mosi} = 3'h2;
   // four mclk per phase keeps each phase above the three-cycle floor
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_mosi <= tx[i];
         repeat (4) @(posedge mclk);
         spi_sclk <= 1'b1;
         rx[i] = spi_miso;
         repeat (4) @(posedge mclk);
         spi_sclk <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      spi_cs_n <= 1'b1;
      spi_mosi <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
endmodule

// ===== tb/test_field_threshold_trim_filter_cfg.sv
// bench: table of field samples, then hand-written cases
// assumes the host model drives spi, checker bound below
`timescale 1ns/1ps
`include "field_cfg_map.svh"
module test_field_threshold_trim_filter_cfg;
   import field_cfg_pkg::*;
   logic           mclk = 1'b0, rst = 1'b1, hall_ok = 1'b1, sample_valid = 1'b0;
   logic           spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, startup_done;
   logic           field_low_flag_pin, field_high_flag_pin;
   logic [7:0]     field_mt = 8'h00, st;
   logic [15:0]    angle_in = 16'h0000, angle_out, rx;
   trim_out_type   trim_out;
   filter_out_type filter_out;
   int             err_count, tests_run, cyc;
   // field in the upper byte, status it must give in the lower
   logic [15:0]    rows [8] = '{16'h3C0C, 16'h82BC, 16'h7ABC, 16'h770C, 16'h160C, 16'h1340, 16'h1940, 16'h1A0C};
   field_threshold_trim_filter_cfg #(.cycles_per_us(1)) field_threshold_trim_filter_cfg_i (.*);
   field_spi_host field_spi_host_i (.*);
   initial forever #5 mclk = ~mclk;
   // hang guard, well above the seventeen thousand cycles needed
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %0t seen %h wanted %h", $time, s, e);
      end
   endtask
   // reply byte comes back in the frame after the command
   task automatic rd(input logic [4:0] a);
      field_spi_host_i.xfer({`SPI_CMD_READ, a, 8'h00}, rx);
      field_spi_host_i.xfer(16'h0000, rx);
      st = rx[15:8];
      chk(rx[7:0], 8'h00);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      field_spi_host_i.xfer({`SPI_CMD_WRITE, a, d}, rx);
   endtask
   // one-cycle sample, then room for flag and range to settle
   task automatic smp(input logic [7:0] f);
      field_mt <= f;
      angle_in <= {f, ~f};
      sample_valid <= 1'b1;
      @(posedge mclk);
      sample_valid <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      chk({trim_out, field_low_flag_pin, field_high_flag_pin, startup_done, spi_miso, spi_miso_oe}, 21'h00_0000);
      rst <= 1'b0;
      repeat (11900) @(posedge mclk);
      chk(startup_done, 1'b0);
      repeat (200) @(posedge mclk);
      chk(startup_done, 1'b1);
      chk(filter_out, {4'h4, 15'h0400, 13'h0172});
      rd(`ADDR_BIAS_TRIM);
      chk(st, `RST_BIAS_TRIM);
      $display("reset done");
      smp(8'h3C);
      foreach (rows[i]) begin
         smp(rows[i][15:8]);
         rd(`ADDR_FIELD_STATUS);
         chk(st, rows[i][7:0]);
         chk({field_high_flag_pin, field_low_flag_pin}, rows[i][7:6]);
      end
      // front end not acquiring: in-range field must not read as in range
      hall_ok <= 1'b0;
      rd(`ADDR_FIELD_STATUS);
      chk(st, 8'h04);
      hall_ok <= 1'b1;
      $display("table done");
      wr(`ADDR_FIELD_THRESHOLD, 8'hE0);
      rd(`ADDR_FIELD_THRESHOLD);
      chk(st, 8'hE0);
      smp(8'h3C);
      smp(8'h3C);
      rd(`ADDR_FIELD_STATUS);
      chk(st, 8'hE4);
      wr(`ADDR_BIAS_TRIM, 8'hFF);
      wr(`ADDR_TRIM_ENABLE, 8'h01);
      smp(8'h3C);
      chk(trim_out, 16'hFF00);
      wr(`ADDR_TRIM_ENABLE, 8'h03);
      smp(8'h3C);
      chk(trim_out, 16'hFFFF);
      rd(`ADDR_TRIM_ENABLE);
      chk(st, 8'h03);
      rd(5'h1F);
      chk(st, 8'h00);
      wr(`ADDR_FILTER_WINDOW, 8'hBB);
      smp(8'h3C);
      chk(filter_out, {4'h8, 15'h4000, 13'h0017});
      rd(`ADDR_FILTER_WINDOW);
      chk(st, 8'hBB);
      $display("hand tests done");
      give_verdict();
   end
endmodule
bind field_threshold_trim_filter_cfg field_cfg_assertions field_cfg_assertions_i (.*);
